// [hdl/afo_core.v]
// Purpose: Alarm comparison, fault routing, analog output and log pacing
// Assumes: A slave protocol stack ahead of this block decodes frames and
//   hands over single register reads and writes on the register port
// Notes: Measured values arrive as unsigned 16-bit samples with a strobe
// How it works
// - Four alarm modes: above, below, outside window, inside window.
// - Above mode clears only below upper threshold minus hysteresis.
// - Below mode clears only above lower threshold plus hysteresis.
// - Inside mode clears after leaving window by more than hysteresis.
// - Outside mode clears after re-entering window beyond hysteresis.
// - Alarm may drive relay, analog output, or both.
// - Enabled fault or alarm forces analog output to 21 mA or 10.5 V.
// - Any combination of under/over range, chain, log, clock and memory faults may drive the relay; sensor fault cannot.
// - A setting picks open or closed contact during alarm.
// - Relay alarm may follow a chosen pulse input level.
// - Analog output source selectable among four, voltage or current.
// - Input span maps linearly onto output span.
// - Manual mode drives analog output from the bus-written value.
// - Sixteen-bit status word with eleven flags from bit zero up.
// - Sensor type coded 0 to 28.
// - Output configuration word field layout.
// - Period measured in microseconds; no pulses means period to max.
// - Log interval 1 s to about 18 h, one record per interval.
// - Each record carries the clock timestamp.
// - Serial settings match on both ends.
// - Logging and clock faults follow stick and battery status.
// - Only read and write register function codes are served.
`timescale 1ns/1ps
`include "afo_defs.vh"
module afo_core #(
  parameter W = 16,
  parameter PERIOD_MAX_US = 32'hffffffff,
  parameter US_PER_SEC = `AFO_SEC_US
) (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Register port from the slave stack (word addressed)
  input wire reg_wr,
  input wire reg_rd,
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  output reg [15:0] reg_rdata_q,
  output reg reg_err_q,
  // Measurement inputs
  input wire sample_valid,
  input wire [W-1:0] analog_value,
  input wire [W-1:0] total_value,
  input wire over_range,
  input wire under_range,
  input wire sensor_fault,
  input wire measurement_chain_fault,
  input wire mem_fault,
  input wire pulse_in,
  // Storage and clock status
  input wire stick_present,
  input wire stick_recognised,
  input wire battery_ok,
  input wire [47:0] rtc_time,
  // Outputs
  output reg relay_q,
  output reg [W-1:0] aout_q,
  output reg aout_current_q,
  output reg alarm_q,
  output reg [31:0] period_us_q,
  output reg [W-1:0] freq_q,
  output reg log_req_q,
  output reg [47:0] log_stamp_q,
  output reg [15:0] log_status_q
);
  // Configuration registers
  reg [15:0] input_type_q;
  reg [15:0] out_cfg_q;
  reg [15:0] manual_q;
  reg [W-1:0] thr_hi_q;
  reg [W-1:0] thr_lo_q;
  reg [W-1:0] hyst_q;
  reg [15:0] relay_cfg_q;
  reg [W-1:0] in_begin_q;
  reg [W-1:0] in_end_q;
  reg [W-1:0] out_begin_q;
  reg [W-1:0] out_end_q;
  reg [15:0] log_int_q;
  // Fault and status
  wire log_fault;
  wire rtc_fault;
  wire [6:0] fault_vec;
  wire [6:0] aout_fault_en;
  wire [6:0] relay_fault_en;
  wire aout_force;
  wire relay_active;
  wire din_match;
  wire global_fault;
  wire [15:0] status_word;
  reg alarm_d;
  // Source path
  reg [W-1:0] src_value;
  wire [W-1:0] scaled;
  // Pulse timing
  reg [6:0] us_div_q;
  reg [31:0] per_cnt_q;
  reg pulse_prev_q;
  wire pulse_rise;
  wire us_tick;
  // Log pacing
  reg [19:0] sec_us_q;
  reg [15:0] log_cnt_q;
  wire sec_tick;
  wire [15:0] log_int_eff;
  wire [31:0] freq_full;

  // Unsigned saturating helpers keep hysteresis bands within range
  function [W-1:0] sat_sub;
    input [W-1:0] a;
    input [W-1:0] b;
    begin
      sat_sub = (a > b) ? (a - b) : {W{1'b0}};
    end
  endfunction

  function [W-1:0] sat_add;
    input [W-1:0] a;
    input [W-1:0] b;
    reg [W:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      sat_add = s[W] ? {W{1'b1}} : s[W-1:0];
    end
  endfunction

  // Decode of the writable register set, used by write and read paths
  function is_rw_addr;
    input [15:0] a;
    begin
      case (a)
        `AFO_ADDR_INPUT_TYPE, `AFO_ADDR_OUT_CFG, `AFO_ADDR_MANUAL,
        `AFO_ADDR_THR_HI, `AFO_ADDR_THR_LO, `AFO_ADDR_HYST,
        `AFO_ADDR_RELAY_CFG, `AFO_ADDR_IN_BEGIN, `AFO_ADDR_IN_END,
        `AFO_ADDR_OUT_BEGIN, `AFO_ADDR_OUT_END, `AFO_ADDR_LOG_INTERVAL:
          is_rw_addr = 1'b1;
        default:
          is_rw_addr = 1'b0;
      endcase
    end
  endfunction

  // Register writes; the stack only issues read or write function codes
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      input_type_q <= 16'h0000;
      out_cfg_q <= 16'h0000;
      manual_q <= 16'h0000;
      thr_hi_q <= {W{1'b0}};
      thr_lo_q <= {W{1'b0}};
      hyst_q <= {W{1'b0}};
      relay_cfg_q <= 16'h0000;
      in_begin_q <= {W{1'b0}};
      in_end_q <= {W{1'b1}};
      out_begin_q <= {W{1'b0}};
      out_end_q <= {W{1'b1}};
      log_int_q <= `AFO_LOG_MIN_S;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        // Out-of-range sensor codes are refused, old code kept
        `AFO_ADDR_INPUT_TYPE:
          if (reg_wdata <= `AFO_SENSOR_MAX)
            input_type_q <= reg_wdata;
        // Only the thirteen defined bits are stored
        `AFO_ADDR_OUT_CFG: out_cfg_q <= {3'b000, reg_wdata[12:0]};
        `AFO_ADDR_MANUAL: manual_q <= reg_wdata;
        `AFO_ADDR_THR_HI: thr_hi_q <= reg_wdata[W-1:0];
        `AFO_ADDR_THR_LO: thr_lo_q <= reg_wdata[W-1:0];
        `AFO_ADDR_HYST: hyst_q <= reg_wdata[W-1:0];
        `AFO_ADDR_RELAY_CFG: relay_cfg_q <= reg_wdata;
        `AFO_ADDR_IN_BEGIN: in_begin_q <= reg_wdata[W-1:0];
        `AFO_ADDR_IN_END: in_end_q <= reg_wdata[W-1:0];
        `AFO_ADDR_OUT_BEGIN: out_begin_q <= reg_wdata[W-1:0];
        `AFO_ADDR_OUT_END: out_end_q <= reg_wdata[W-1:0];
        // Interval clamped to 1 s .. about 18 h
        `AFO_ADDR_LOG_INTERVAL:
          if (reg_wdata < `AFO_LOG_MIN_S)
            log_int_q <= `AFO_LOG_MIN_S;
          else if ({1'b0, reg_wdata} > `AFO_LOG_MAX_S)
            log_int_q <= 16'hfd20;
          else
            log_int_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Register reads, one cycle latency; unmapped addresses flag an error
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reg_rdata_q <= 16'h0000;
      reg_err_q <= 1'b0;
    end
    else
    begin
      reg_err_q <= (reg_rd || reg_wr) && !is_rw_addr(reg_addr)
        && !(reg_rd && reg_addr == `AFO_ADDR_STATUS);
      if (reg_rd)
      begin
        case (reg_addr)
          `AFO_ADDR_INPUT_TYPE: reg_rdata_q <= input_type_q;
          `AFO_ADDR_OUT_CFG: reg_rdata_q <= out_cfg_q;
          `AFO_ADDR_STATUS: reg_rdata_q <= status_word;
          `AFO_ADDR_MANUAL: reg_rdata_q <= manual_q;
          `AFO_ADDR_THR_HI: reg_rdata_q <= thr_hi_q;
          `AFO_ADDR_THR_LO: reg_rdata_q <= thr_lo_q;
          `AFO_ADDR_HYST: reg_rdata_q <= hyst_q;
          `AFO_ADDR_RELAY_CFG: reg_rdata_q <= relay_cfg_q;
          `AFO_ADDR_IN_BEGIN: reg_rdata_q <= in_begin_q;
          `AFO_ADDR_IN_END: reg_rdata_q <= in_end_q;
          `AFO_ADDR_OUT_BEGIN: reg_rdata_q <= out_begin_q;
          `AFO_ADDR_OUT_END: reg_rdata_q <= out_end_q;
          `AFO_ADDR_LOG_INTERVAL: reg_rdata_q <= log_int_q;
          default: reg_rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  // Storage and clock faults are plain conditions of the status pins
  assign log_fault = !stick_present || !stick_recognised;
  assign rtc_fault = !battery_ok;

  // Fault vector in enable-field order
  assign fault_vec = {alarm_q, mem_fault, rtc_fault, log_fault,
    measurement_chain_fault, over_range, under_range};
  // Alarm may reach analog output, relay or both
  assign aout_fault_en = {out_cfg_q[`AFO_CFG_FAULT_LSB + `AFO_FE_ALARM]
    && relay_cfg_q[`AFO_RC_AOUT_ALARM_EN], out_cfg_q[`AFO_CFG_FAULT_LSB +: 6]};
  // Relay fault enables are independent of the analog ones
  assign relay_fault_en = {relay_cfg_q[`AFO_RC_ALARM_EN],
    relay_cfg_q[`AFO_RC_FAULT_LSB +: 6]};

  assign aout_force = |(fault_vec & aout_fault_en);
  // Relay can follow the pulse input level, ORed with the compare and fault terms
  assign din_match = relay_cfg_q[`AFO_RC_DIN_EN]
    && (pulse_in == relay_cfg_q[`AFO_RC_DIN_HIGH]);
  assign relay_active = (|(fault_vec & relay_fault_en)) || din_match;
  assign global_fault = measurement_chain_fault || log_fault || rtc_fault
    || mem_fault || sensor_fault;

  // Status word, flags from bit zero upward
  assign status_word = {5'b00000, sensor_fault, mem_fault, rtc_fault, log_fault,
    measurement_chain_fault, relay_q, pulse_in, under_range, over_range,
    alarm_q, global_fault};

  // Alarm compare: set immediately on a sample, clear past hysteresis
  always @*
  begin
    alarm_d = alarm_q;
    if (sample_valid)
    begin
      case (out_cfg_q[`AFO_CFG_MODE_LSB +: 2])
        `AFO_MODE_ABOVE:
          if (analog_value > thr_hi_q)
            alarm_d = 1'b1;
          else if (analog_value < sat_sub(thr_hi_q, hyst_q))
            alarm_d = 1'b0;
        `AFO_MODE_BELOW:
          if (analog_value < thr_lo_q)
            alarm_d = 1'b1;
          else if (analog_value > sat_add(thr_lo_q, hyst_q))
            alarm_d = 1'b0;
        `AFO_MODE_OUTSIDE:
          if (analog_value > thr_hi_q || analog_value < thr_lo_q)
            alarm_d = 1'b1;
          else if (analog_value < sat_sub(thr_hi_q, hyst_q)
            && analog_value > sat_add(thr_lo_q, hyst_q))
            alarm_d = 1'b0;
        `AFO_MODE_INSIDE:
          if (analog_value >= thr_lo_q && analog_value <= thr_hi_q)
            alarm_d = 1'b1;
          else if (analog_value > sat_add(thr_hi_q, hyst_q)
            || analog_value < sat_sub(thr_lo_q, hyst_q))
            alarm_d = 1'b0;
        default:
          alarm_d = alarm_q;
      endcase
    end
  end

  // Source selection for the analog output
  always @*
  begin
    case (out_cfg_q[`AFO_CFG_SRC_LSB +: 2])
      `AFO_SRC_ANALOG: src_value = analog_value;
      `AFO_SRC_FREQ: src_value = freq_q;
      `AFO_SRC_PERIOD: src_value = (|period_us_q[31:W]) ? {W{1'b1}} : period_us_q[W-1:0];
      `AFO_SRC_TOTAL: src_value = total_value;
      default: src_value = analog_value;
    endcase
  end

  afo_scale #(
    .W(W)
  ) u_scale (
    .core_clk(core_clk),
    .rstn(rstn),
    .in_begin(in_begin_q),
    .in_end(in_end_q),
    .out_begin(out_begin_q),
    .out_end(out_end_q),
    .value(src_value),
    .result_q(scaled)
  );

  // Alarm, relay and analog output registers
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      alarm_q <= 1'b0;
      relay_q <= 1'b0;
      aout_q <= {W{1'b0}};
      aout_current_q <= 1'b0;
    end
    else
    begin
      alarm_q <= alarm_d;
      // Contact level during alarm is a setting; default open
      relay_q <= relay_active ? relay_cfg_q[`AFO_RC_CONTACT_CLOSED]
        : !relay_cfg_q[`AFO_RC_CONTACT_CLOSED];
      aout_current_q <= out_cfg_q[`AFO_CFG_CURRENT];
      // Forced level wins over manual and scaled values
      if (aout_force)
        aout_q <= out_cfg_q[`AFO_CFG_CURRENT] ? `AFO_FORCE_UA : `AFO_FORCE_MV;
      else if (out_cfg_q[`AFO_CFG_MANUAL])
        aout_q <= manual_q[W-1:0];
      else
        aout_q <= scaled;
    end
  end

  // Microsecond tick from the core clock
  assign us_tick = (us_div_q == `AFO_US_CYCLES - 1);
  assign pulse_rise = pulse_in && !pulse_prev_q;
  // Full-width quotient, saturated to the output width below
  assign freq_full = US_PER_SEC / period_us_q;

  // Period measured between rising edges, saturating when idle
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      us_div_q <= 7'h00;
      per_cnt_q <= 32'h00000000;
      pulse_prev_q <= 1'b0;
      period_us_q <= PERIOD_MAX_US;
      freq_q <= {W{1'b0}};
    end
    else
    begin
      us_div_q <= us_tick ? 7'h00 : us_div_q + 7'h01;
      pulse_prev_q <= pulse_in;
      if (pulse_rise)
      begin
        period_us_q <= per_cnt_q;
        per_cnt_q <= 32'h00000000;
      end
      else if (us_tick && per_cnt_q != PERIOD_MAX_US)
        per_cnt_q <= per_cnt_q + 32'h00000001;
      // Without edges the running count becomes the period
      if (!pulse_rise && per_cnt_q > period_us_q)
        period_us_q <= per_cnt_q;
      // Frequency in Hz tends to zero as the period grows
      if (period_us_q == 32'h00000000)
        freq_q <= {W{1'b0}};
      else
        freq_q <= (freq_full > {{(32-W){1'b0}}, {W{1'b1}}}) ? {W{1'b1}}
          : freq_full[W-1:0];
    end
  end

  // Interval used by the pacer
  assign log_int_eff = log_int_q;
  assign sec_tick = us_tick && (sec_us_q == US_PER_SEC - 1);

  // One record per interval, stamped with the clock time
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sec_us_q <= 20'h00000;
      log_cnt_q <= 16'h0000;
      log_req_q <= 1'b0;
      log_stamp_q <= 48'h000000000000;
      log_status_q <= 16'h0000;
    end
    else
    begin
      log_req_q <= 1'b0;
      if (us_tick)
        sec_us_q <= sec_tick ? 20'h00000 : sec_us_q + 20'h00001;
      if (sec_tick)
      begin
        if (log_cnt_q + 16'h0001 >= log_int_eff)
        begin
          log_cnt_q <= 16'h0000;
          log_req_q <= 1'b1;
          log_stamp_q <= rtc_time;
          log_status_q <= status_word;
        end
        else
          log_cnt_q <= log_cnt_q + 16'h0001;
      end
    end
  end
endmodule // afo_core

// [hdl/afo_defs.vh]
// Purpose: Shared constants for the alarm and fault output block
// Assumes: Word addresses as seen from the register port of the slave stack
// Notes: Definitions only
`ifndef AFO_DEFS_VH
`define AFO_DEFS_VH
// Register addresses
`define AFO_ADDR_INPUT_TYPE 16'h0065
`define AFO_ADDR_OUT_CFG 16'h006a
`define AFO_ADDR_STATUS 16'h9c45
`define AFO_ADDR_MANUAL 16'h0008
`define AFO_ADDR_THR_HI 16'h0200
`define AFO_ADDR_THR_LO 16'h0201
`define AFO_ADDR_HYST 16'h0202
`define AFO_ADDR_RELAY_CFG 16'h0203
`define AFO_ADDR_IN_BEGIN 16'h0204
`define AFO_ADDR_IN_END 16'h0205
`define AFO_ADDR_OUT_BEGIN 16'h0206
`define AFO_ADDR_OUT_END 16'h0207
`define AFO_ADDR_LOG_INTERVAL 16'h0208
// Output configuration fields
`define AFO_CFG_CURRENT 0
`define AFO_CFG_SRC_LSB 1
`define AFO_CFG_FAULT_LSB 3
`define AFO_CFG_MODE_LSB 10
`define AFO_CFG_MANUAL 12
// Fault enable bit order within the 7-bit group
`define AFO_FE_UNDER 0
`define AFO_FE_OVER 1
`define AFO_FE_HW 2
`define AFO_FE_LOG 3
`define AFO_FE_RTC 4
`define AFO_FE_MEM 5
`define AFO_FE_ALARM 6
// Relay configuration fields
`define AFO_RC_ALARM_EN 0
`define AFO_RC_CONTACT_CLOSED 1
`define AFO_RC_DIN_EN 2
`define AFO_RC_DIN_HIGH 3
`define AFO_RC_AOUT_ALARM_EN 4
`define AFO_RC_FAULT_LSB 8
// Threshold modes
`define AFO_MODE_ABOVE 2'd0
`define AFO_MODE_BELOW 2'd1
`define AFO_MODE_OUTSIDE 2'd2
`define AFO_MODE_INSIDE 2'd3
// Source selection
`define AFO_SRC_ANALOG 2'd0
`define AFO_SRC_FREQ 2'd1
`define AFO_SRC_PERIOD 2'd2
`define AFO_SRC_TOTAL 2'd3
// Forced output levels, uA and mV
`define AFO_FORCE_UA 16'h5208
`define AFO_FORCE_MV 16'h2904
// Sensor code limit, 28 is the last thermocouple
`define AFO_SENSOR_MAX 16'h001c
// Log interval bounds in seconds (1 s to about 18 h)
`define AFO_LOG_MIN_S 16'h0001
`define AFO_LOG_MAX_S 17'd64800
// Clock and time base
`define AFO_CLK_MHZ 125
`define AFO_US_NS 1000
`define AFO_CLK_NS 8
`define AFO_US_CYCLES (`AFO_US_NS / `AFO_CLK_NS)
`define AFO_SEC_US 1000000
`endif

// [hdl/afo_scale.v]
// Purpose: Linear range mapping from input span onto output span
// Assumes: Unsigned 16-bit values, begin below or above end
// Notes: One-cycle registered result
`timescale 1ns/1ps
module afo_scale #(
  parameter W = 16
) (
  // Clock and reset
  input wire core_clk,
  input wire rstn,
  // Ranges and value
  input wire [W-1:0] in_begin,
  input wire [W-1:0] in_end,
  input wire [W-1:0] out_begin,
  input wire [W-1:0] out_end,
  input wire [W-1:0] value,
  // Result
  output reg [W-1:0] result_q
);
  wire signed [W+1:0] in_span;
  wire signed [W+1:0] out_span;
  wire signed [W+1:0] offs;
  wire signed [2*W+3:0] prod;
  wire signed [2*W+3:0] quot;
  wire signed [2*W+3:0] res;
  reg [W-1:0] result_d;

  // Signed spans allow falling output ranges
  assign in_span = $signed({2'b00, in_end}) - $signed({2'b00, in_begin});
  assign out_span = $signed({2'b00, out_end}) - $signed({2'b00, out_begin});
  assign offs = $signed({2'b00, value}) - $signed({2'b00, in_begin});
  assign prod = offs * out_span;
  // A zero input span would divide by zero, so it maps to the begin value
  assign quot = (in_span == 0) ? {(2*W+4){1'b0}} : prod / in_span;
  assign res = quot + $signed({{(W+4){1'b0}}, out_begin});

  // Clamp to the representable range
  always @*
  begin
    if (res < 0)
      result_d = {W{1'b0}};
    else if (res > $signed({{(W+4){1'b0}}, {W{1'b1}}}))
      result_d = {W{1'b1}};
    else
      result_d = res[W-1:0];
  end

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      result_q <= {W{1'b0}};
    else
      result_q <= result_d;
  end
endmodule // afo_scale

// [bench/afo_core_properties.sv]
// Purpose: Port timing relations of the alarm and fault output core
// Assumes: One clock domain, asynchronous active-low reset
// Notes: Shadows of three settings tie outputs to what was written
`timescale 1ns/1ps
`include "afo_defs.vh"
module afo_core_properties #(
  parameter W = 16
) (
  // Clock and reset
  input logic core_clk,
  input logic rstn,
  // Register port
  input logic reg_wr,
  input logic reg_rd,
  input logic [15:0] reg_addr,
  input logic [15:0] reg_wdata,
  input logic reg_err_q,
  // Sample side
  input logic sample_valid,
  input logic under_range,
  // Outputs
  input logic relay_q,
  input logic [W-1:0] aout_q,
  input logic aout_current_q,
  input logic alarm_q,
  input logic log_req_q
);
  logic [15:0] cfg_q;
  logic [15:0] rc_q;
  logic [15:0] mv_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  // Shadow settings, taken at the same edge as the core takes them
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_q <= 16'h0000;
      rc_q <= 16'h0000;
      mv_q <= 16'h0000;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `AFO_ADDR_OUT_CFG) cfg_q <= {3'h0, reg_wdata[12:0]};
      if (reg_addr == `AFO_ADDR_RELAY_CFG) rc_q <= reg_wdata;
      if (reg_addr == `AFO_ADDR_MANUAL) mv_q <= reg_wdata;
    end
  end
  property p_unmapped;
    reg_rd && reg_addr == 16'h0100 |=> reg_err_q;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not flagged");
  property p_status_ro;
    reg_wr && reg_addr == `AFO_ADDR_STATUS |=> reg_err_q;
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write accepted");
  property p_log_gap;
    log_req_q |=> !log_req_q [*8];
  endproperty
  a_log_gap: assert property (p_log_gap) else $error("log pulses too close");
  property p_alarm_sample;
    $changed(alarm_q) |-> $past(sample_valid);
  endproperty
  a_alarm_sample: assert property (p_alarm_sample) else $error("alarm moved off a sample");
  property p_force;
    (!cfg_q[12] && cfg_q[3] && under_range && $stable(cfg_q)) [*3]
      |-> aout_q == (cfg_q[0] ? `AFO_FORCE_UA : `AFO_FORCE_MV);
  endproperty
  a_force: assert property (p_force) else $error("output not forced on fault");
  property p_mode;
    $stable(cfg_q) [*3] |-> aout_current_q == cfg_q[0];
  endproperty
  a_mode: assert property (p_mode) else $error("output mode differs from setting");
  property p_relay;
    (rc_q[0] && !rc_q[2] && rc_q[13:8] == 6'h00 && $stable(rc_q) && $stable(alarm_q)) [*2]
      |-> relay_q == (alarm_q ? rc_q[1] : !rc_q[1]);
  endproperty
  a_relay: assert property (p_relay) else $error("relay contact wrong for alarm");
  property p_manual;
    (cfg_q[12] && cfg_q[9:3] == 7'h00 && $stable(cfg_q) && $stable(mv_q)) [*3]
      |-> aout_q == mv_q;
  endproperty
  a_manual: assert property (p_manual) else $error("manual value not on output");
endmodule // afo_core_properties

bind afo_core afo_core_properties #(.W(W)) u_props (.core_clk(core_clk), .rstn(rstn),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_err_q(reg_err_q), .sample_valid(sample_valid), .under_range(under_range),
  .relay_q(relay_q), .aout_q(aout_q), .aout_current_q(aout_current_q), .alarm_q(alarm_q),
  .log_req_q(log_req_q));

// [bench/afo_master.sv]
// Purpose: Bus master side of the register port, one access at a time
// Assumes: Strobes are single-cycle pulses launched just after a rising edge
// Notes: Released write data shows the inverse so stale words are not trusted
`timescale 1ns/1ps
module afo_master (
  // Clock
  input logic core_clk,
  // Register port towards the core
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input logic [15:0] reg_rdata_q,
  input logic reg_err_q
);
  // Idle bus at time zero
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 34'h0;
  // Single-register write; settled one step after the taking edge
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask
  // Single-register read; word taken after it lands
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata_q;
    e = reg_err_q;
  endtask
endmodule // afo_master

// [bench/test_alarm_fail_output_logic.sv]
// Purpose: Self-checking bench for the alarm and fault output core
// Assumes: A shortened second so log pacing fits a short run
// Notes: Alarm state is modelled with integers and compared on every sample
`timescale 1ns/1ps
`include "afo_defs.vh"
module test_alarm_fail_output_logic;
  localparam int USEC = 10;
  logic core_clk, rstn, sample_valid, over_range, under_range, sensor_fault, mem_fault;
  logic measurement_chain_fault, pulse_in, stick_present, stick_recognised, battery_ok;
  logic reg_wr, reg_rd, reg_err_q, relay_q, aout_current_q, alarm_q, log_req_q, rd_e;
  logic [15:0] analog_value, total_value, seed, rd_d, reg_addr, reg_wdata, reg_rdata_q, aout_q;
  logic [15:0] freq_q, log_status_q;
  logic [31:0] period_us_q;
  logic [47:0] rtc_time, log_stamp_q;
  int num_errors = 0;
  int num_checks = 0;
  int hi, lo, hy, mode, alm, rc, v, n;
  int vals[13] = '{101, 95, 90, 89, 49, 60, 61, 75, 45, 40, 39, 111, 110};
  afo_core #(.US_PER_SEC(USEC)) dut (.*);
  afo_master u_mst (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
    .reg_err_q(reg_err_q));
  // 125 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Stimulus shift register
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Reference alarm: set wins, hysteresis only delays clearing
  function automatic int alarm_next(input int x, input int a);
    int s;
    int c;
    s = (mode == 0) ? (x > hi) : (mode == 1) ? (x < lo)
      : (mode == 2) ? (x > hi || x < lo) : (x >= lo && x <= hi);
    c = (mode == 0) ? (x < hi - hy) : (mode == 1) ? (x > lo + hy)
      : (mode == 2) ? (x < hi - hy && x > lo + hy) : (x < lo - hy || x > hi + hy);
    return s ? 1 : (c ? 0 : a);
  endfunction
  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    if (num_errors == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One sample; alarm next edge, relay and output one later
  task automatic smp(input int x, input int ea);
    @(posedge core_clk);
    sample_valid <= 1'b1;
    analog_value <= x[15:0];
    @(posedge core_clk);
    sample_valid <= 1'b0;
    alm = alarm_next(x, alm);
    #1;
    chk(alarm_q, alm);
    @(posedge core_clk);
    #1;
    if (rc[0]) chk(relay_q, alm ? rc[1] : !rc[1]);
    if (ea >= 0) chk(aout_q, ea);
  endtask
  // Bounded wait for a log pulse
  task automatic wait_log();
    n = 0;
    do
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    while (log_req_q !== 1'b1 && n < 6000);
    if (n >= 6000)
    begin
      num_errors++;
      $display("ERROR %0t: log pulse missing", $time);
      stop_test();
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  // Main sequence
  initial
  begin
    {rstn, sample_valid, over_range, under_range, sensor_fault, mem_fault} = 6'h00;
    {measurement_chain_fault, pulse_in, stick_present, stick_recognised, battery_ok} = 5'h07;
    {analog_value, total_value, rtc_time} = 80'h0;
    seed = 16'he28d;
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    #1;
    chk(relay_q, 1);
    chk(period_us_q, 32'hffffffff);
    chk(freq_q, 0);
    u_mst.wr(`AFO_ADDR_OUT_CFG, 16'hffff);
    u_mst.rd(`AFO_ADDR_OUT_CFG, rd_d, rd_e);
    chk(rd_d, 16'h1fff);
    u_mst.wr(`AFO_ADDR_INPUT_TYPE, 16'd28);
    u_mst.wr(`AFO_ADDR_INPUT_TYPE, 16'd29);
    u_mst.rd(`AFO_ADDR_INPUT_TYPE, rd_d, rd_e);
    chk(rd_d, 16'd28);
    u_mst.wr(`AFO_ADDR_LOG_INTERVAL, 16'h0000);
    u_mst.rd(`AFO_ADDR_LOG_INTERVAL, rd_d, rd_e);
    chk(rd_d, 16'h0001);
    u_mst.rd(16'h0100, rd_d, rd_e);
    chk(rd_e, 1);
    u_mst.wr(`AFO_ADDR_STATUS, 16'h0000);
    chk(reg_err_q, 1);
    // All modes over fixed boundaries, then random
    hi = 100;
    lo = 50;
    hy = 10;
    rc = 3;
    alm = 0;
    u_mst.wr(`AFO_ADDR_THR_HI, 16'd100);
    u_mst.wr(`AFO_ADDR_THR_LO, 16'd50);
    u_mst.wr(`AFO_ADDR_HYST, 16'd10);
    u_mst.wr(`AFO_ADDR_RELAY_CFG, 16'h0003);
    for (mode = 0; mode < 4; mode++)
    begin
      u_mst.wr(`AFO_ADDR_OUT_CFG, {4'h0, mode[1:0], 10'h000});
      foreach (vals[i]) smp(vals[i], -1);
      repeat (20)
      begin
        seed = lfsr_next(seed);
        smp(seed % 200, -1);
      end
    end
    // Scaled analog output in current mode
    mode = 0;
    hi = 65535;
    hy = 0;
    rc = 16'h0013;
    u_mst.wr(`AFO_ADDR_THR_HI, 16'hffff);
    u_mst.wr(`AFO_ADDR_HYST, 16'h0000);
    u_mst.wr(`AFO_ADDR_IN_BEGIN, 16'd100);
    u_mst.wr(`AFO_ADDR_IN_END, 16'd1100);
    u_mst.wr(`AFO_ADDR_OUT_BEGIN, 16'd4000);
    u_mst.wr(`AFO_ADDR_OUT_END, 16'd20000);
    u_mst.wr(`AFO_ADDR_RELAY_CFG, 16'h0013);
    u_mst.wr(`AFO_ADDR_OUT_CFG, 16'h0209);
    smp(500, -1);
    repeat (16)
    begin
      seed = lfsr_next(seed);
      v = 100 + seed % 1001;
      smp(v, 4000 + (v - 100) * 16);
    end
    chk(aout_current_q, 1);
    // Alarm and fault forcing of the output
    hi = 100;
    u_mst.wr(`AFO_ADDR_THR_HI, 16'd100);
    smp(500, -1);
    settle();
    chk(aout_q, 21000);
    u_mst.wr(`AFO_ADDR_OUT_CFG, 16'h0208);
    settle();
    chk(aout_q, 10500);
    smp(50, -1);
    under_range <= 1'b1;
    settle();
    chk(aout_q, 10500);
    under_range <= 1'b0;
    u_mst.wr(`AFO_ADDR_OUT_CFG, 16'h1001);
    u_mst.wr(`AFO_ADDR_MANUAL, 16'd1234);
    settle();
    chk(aout_q, 1234);
    u_mst.wr(`AFO_ADDR_OUT_CFG, 16'h0007);
    @(posedge core_clk);
    total_value <= 16'd250;
    smp(500, 6400);
    // Fault sources on the relay and in the status word
    rc = 16'h0402;
    u_mst.wr(`AFO_ADDR_RELAY_CFG, 16'h0402);
    smp(50, -1);
    measurement_chain_fault <= 1'b1;
    stick_present <= 1'b0;
    settle();
    chk(relay_q, 1);
    u_mst.rd(`AFO_ADDR_STATUS, rd_d, rd_e);
    chk(rd_d & 16'hfffe, 16'h00e0);
    {over_range, sensor_fault, mem_fault, battery_ok, stick_present} <= 5'b11101;
    u_mst.rd(`AFO_ADDR_STATUS, rd_d, rd_e);
    chk(rd_d & 16'hfffe, 16'h0764);
    // Relay following the pulse input level
    u_mst.wr(`AFO_ADDR_RELAY_CFG, 16'h000e);
    pulse_in <= 1'b1;
    settle();
    chk(relay_q, 1);
    pulse_in <= 1'b0;
    settle();
    chk(relay_q, 0);
    // Log pacing and timestamp
    rtc_time <= {seed, ~seed, seed};
    u_mst.wr(`AFO_ADDR_LOG_INTERVAL, 16'd2);
    wait_log();
    chk(log_stamp_q, rtc_time);
    chk(log_status_q, 16'h0745);
    wait_log();
    chk(n, 2 * USEC * 125);
    stop_test();
  end
endmodule // test_alarm_fail_output_logic
